// ---- fms_pkg.sv ----
package fms_pkg;
  // instruction codes
  localparam logic [7:0] CMD_WRAP_READ = 8'h0C;
  localparam logic [7:0] CMD_SET_PARAMS = 8'hC0;
  localparam logic [7:0] CMD_ENTER_QUAD = 8'h38;
  localparam logic [7:0] CMD_EXIT_QUAD = 8'hFF;
  localparam logic [7:0] CMD_RESET_EN = 8'h66;
  localparam logic [7:0] CMD_RESET = 8'h99;
  // read parameter field positions
  localparam int DUMMY_LSB = 4;
  localparam int WRAP_LSB = 0;
  localparam logic [7:0] PARAMS_RESET = 8'h00;
  localparam logic [2:0] WRAP_BITS_RESET = 3'h0;
  // reset recovery time
  localparam int CLK_MHZ = 50;
  localparam int RESET_TIME_US = 30;
  localparam int RESET_CYCLES = RESET_TIME_US * CLK_MHZ;
  localparam int ADDR_W = 24;
  typedef enum logic [4:0]
  {
    ST_CMD = 5'b00001,
    ST_ADDR = 5'b00010,
    ST_PARAM = 5'b00100,
    ST_DUMMY = 5'b01000,
    ST_DATA = 5'b10000
  } fms_state_t;
endpackage

// ---- fms_core.sv ----
`timescale 1ns/1ns
module fms_core
  import fms_pkg::*;
#(
  parameter int RESET_WAIT = RESET_CYCLES
)
(
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic CE,
  // serial link pins
  input wire logic SCK,
  input wire logic CS_N,
  input wire logic [3:0] IO_IN,
  output logic [3:0] IO_OUT,
  output logic [3:0] IO_OE,
  // status bits
  input wire logic QUAD_ENABLE,
  input wire logic WEL_SET,
  input wire logic SUS_SET,
  input wire logic [7:0] READ_DATA,
  output logic QUAD_MODE,
  output logic WRITE_ENABLE_LATCH,
  output logic SUSPEND_STATUS,
  output logic BUSY,
  output logic ABORT,
  output logic [ADDR_W-1:0] READ_ADDR,
  output logic [7:0] READ_PARAMS,
  output logic [7:0] CONT_READ_MODE,
  output logic [2:0] WRAP_BITS
);
  ////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [2:0] sck_s;
  logic [1:0] cs_s;
  logic [3:0] io_s1, io_s2;
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      sck_s <= 3'h0;
      cs_s <= 2'h3;
      io_s1 <= 4'h0;
      io_s2 <= 4'h0;
    end
    else if (CE)
    begin
      sck_s <= {sck_s[1:0], SCK};
      cs_s <= {cs_s[0], CS_N};
      io_s1 <= IO_IN;
      io_s2 <= io_s1;
    end
  end
  // edges judged on the second and third stages only
  wire sck_rise = sck_s[1] & ~sck_s[2];
  wire sck_fall = ~sck_s[1] & sck_s[2];
  wire sel = ~cs_s[1];

  function automatic logic [3:0] dummy_count(input logic [1:0] code);
    dummy_count = {1'b0, code, 1'b0} + 4'h2;
  endfunction
  function automatic logic [6:0] wrap_len(input logic [1:0] code);
    wrap_len = 7'h08 << code;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // instruction shifter
  fms_state_t state;
  logic [7:0] shreg;
  logic [4:0] cnt;
  logic [7:0] cmd;
  logic cmd_done;
  logic [ADDR_W-1:0] base;
  logic [7:0] dout;
  logic reset_armed;
  logic [31:0] wait_cnt;
  wire [3:0] step = QUAD_MODE ? 4'h4 : 4'h1;
  wire [7:0] next_shreg = QUAD_MODE ? {shreg[3:0], io_s2}
                                    : {shreg[6:0], io_s2[0]};
  wire [6:0] wlen = wrap_len(READ_PARAMS[WRAP_LSB +: 2]);
  wire [ADDR_W-1:0] wmask = {{(ADDR_W-7){1'b0}}, wlen - 7'h01};
  wire [ADDR_W-1:0] next_addr =
    (READ_ADDR & ~wmask) | ((READ_ADDR + 24'h1) & wmask);

  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      state <= ST_CMD;
      shreg <= 8'h00;
      cnt <= 5'h0;
      cmd <= 8'h00;
      cmd_done <= 1'b0;
      base <= '0;
      dout <= 8'h00;
      READ_ADDR <= '0;
      IO_OUT <= 4'h0;
      IO_OE <= 4'h0;
    end
    else if (CE)
    begin
      cmd_done <= 1'b0;
      if (!sel || BUSY)
      begin
        state <= ST_CMD;
        cnt <= 5'h0;
        IO_OE <= 4'h0;
      end
      else if (sck_rise)
      begin
        shreg <= next_shreg;
        cnt <= cnt + 5'(step);
        case (state)
          ST_CMD:
          begin
            if (cnt + 5'(step) == 5'h8)
            begin
              cmd <= next_shreg;
              cmd_done <= 1'b1;
              cnt <= 5'h0;
              if (QUAD_MODE && next_shreg == CMD_WRAP_READ)
                state <= ST_ADDR;
              else if (QUAD_MODE && next_shreg == CMD_SET_PARAMS)
                state <= ST_PARAM;
            end
          end
          ST_ADDR:
          begin
            base <= {base[ADDR_W-5:0], io_s2};
            if (cnt == 5'd20)
            begin
              READ_ADDR <= {base[ADDR_W-5:0], io_s2};
              cnt <= 5'h0;
              state <= ST_DUMMY;
            end
          end
          ST_PARAM:
          begin
            if (cnt == 5'h4)
              state <= ST_CMD;
          end
          ST_DUMMY:
          begin
            // cnt steps by four per clock in four-bit mode
            if (cnt == 5'({dummy_count(READ_PARAMS[DUMMY_LSB +: 2]) - 4'h1,
                           2'b00}))
            begin
              cnt <= 5'h0;
              dout <= READ_DATA;
              READ_ADDR <= next_addr;
              state <= ST_DATA;
            end
          end
          ST_DATA:
          begin
            // address runs one byte ahead so the next byte is ready
            if (cnt == 5'h4)
            begin
              cnt <= 5'h0;
              dout <= READ_DATA;
              READ_ADDR <= next_addr;
            end
          end
          default: state <= ST_CMD;
        endcase
      end
      else if (sck_fall && state == ST_DATA)
      begin
        IO_OE <= 4'hF;
        IO_OUT <= (cnt == 5'h0) ? dout[7:4] : dout[3:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // parameter capture and mode
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      READ_PARAMS <= PARAMS_RESET;
      QUAD_MODE <= 1'b0;
      WRAP_BITS <= WRAP_BITS_RESET;
      CONT_READ_MODE <= 8'h00;
    end
    else if (CE)
    begin
      if (ABORT)
      begin
        READ_PARAMS <= PARAMS_RESET;
        QUAD_MODE <= 1'b0;
        WRAP_BITS <= WRAP_BITS_RESET;
        CONT_READ_MODE <= 8'h00;
      end
      else if (sck_rise && sel && !BUSY && state == ST_PARAM &&
               cnt == 5'h4)
        READ_PARAMS <= next_shreg;
      else if (cmd_done && !QUAD_MODE && cmd == CMD_ENTER_QUAD &&
               QUAD_ENABLE)
        QUAD_MODE <= 1'b1;
      else if (cmd_done && QUAD_MODE && cmd == CMD_EXIT_QUAD)
        QUAD_MODE <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // software reset; host must check busy and suspend first
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      reset_armed <= 1'b0;
      wait_cnt <= 32'h0;
      BUSY <= 1'b0;
      ABORT <= 1'b0;
    end
    else if (CE)
    begin
      ABORT <= 1'b0;
      if (BUSY)
      begin
        wait_cnt <= wait_cnt + 32'h1;
        if (wait_cnt == 32'(RESET_WAIT) - 32'h1)
        begin
          BUSY <= 1'b0;
          wait_cnt <= 32'h0;
        end
      end
      else if (cmd_done)
      begin
        reset_armed <= (cmd == CMD_RESET_EN);
        if (reset_armed && cmd == CMD_RESET)
        begin
          BUSY <= 1'b1;
          ABORT <= 1'b1;
          reset_armed <= 1'b0;
        end
      end
    end
  end

  // latch and suspend pass through a mode change untouched
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      WRITE_ENABLE_LATCH <= 1'b0;
      SUSPEND_STATUS <= 1'b0;
    end
    else if (CE)
    begin
      if (ABORT)
      begin
        WRITE_ENABLE_LATCH <= 1'b0;
        SUSPEND_STATUS <= 1'b0;
      end
      else
      begin
        WRITE_ENABLE_LATCH <= WRITE_ENABLE_LATCH | WEL_SET;
        SUSPEND_STATUS <= SUSPEND_STATUS | SUS_SET;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  mode_stays_spi_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    CE && cmd_done && !QUAD_MODE && cmd == CMD_ENTER_QUAD && !QUAD_ENABLE
    && !BUSY |=> !QUAD_MODE)
    else $error("enter taken without quad enable");
  mode_enter_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    CE && cmd_done && !QUAD_MODE && cmd == CMD_ENTER_QUAD && QUAD_ENABLE
    && wait_cnt == 32'h0 |=> QUAD_MODE)
    else $error("enter not taken");
  mode_exit_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    CE && cmd_done && QUAD_MODE && cmd == CMD_EXIT_QUAD
    && wait_cnt == 32'h0 |=> !QUAD_MODE)
    else $error("exit not taken");
  reset_start_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    CE && cmd_done && reset_armed && cmd == CMD_RESET && !BUSY
    |=> BUSY && ABORT)
    else $error("reset pair not accepted");
  reset_disarm_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    CE && cmd_done && !BUSY && cmd != CMD_RESET_EN |=> !reset_armed)
    else $error("reset stayed armed");
  reset_clear_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    ABORT && CE |=> !WRITE_ENABLE_LATCH && !SUSPEND_STATUS)
    else $error("volatile bits survived reset");
  busy_quiet_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    BUSY |-> !cmd_done)
    else $error("command taken while busy");
  wrap_stay_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    $changed(READ_ADDR) && state == ST_DATA && $past(state) == ST_DATA
    |-> (READ_ADDR & ~wmask) == ($past(READ_ADDR) & ~wmask))
    else $error("read left wrap window");
  c_enter_c: cover property (@(posedge SYS_CLK) $rose(QUAD_MODE));
  c_reset_c: cover property (@(posedge SYS_CLK) $fell(BUSY));
  c_wrap_c: cover property (@(posedge SYS_CLK)
    state == ST_DATA && (READ_ADDR & wmask) == wmask);
endmodule

// ---- fms_host.sv ----
`timescale 1ns/1ns
module fms_host
(
  // clock
  input wire logic SYS_CLK,
  // link pins
  output logic SCK,
  output logic CS_N,
  output logic [3:0] IO_IN,
  input wire logic [3:0] IO_OUT,
  input wire logic [3:0] IO_OE
);
  // half period of five cycles keeps above the four the pin sync needs
  localparam int HALF = 5;
  initial
  begin
    SCK = 1'b0;
    CS_N = 1'b1;
    IO_IN = 4'h0;
  end
  // released lines show the inverse, never stale data
  task automatic tick(input logic [3:0] v, input logic rel,
    output logic [3:0] r);
    @(posedge SYS_CLK);
    SCK <= 1'b0;
    IO_IN <= rel ? ~IO_IN : v;
    repeat (HALF) @(posedge SYS_CLK);
    r = IO_OUT & IO_OE;
    SCK <= 1'b1;
    repeat (HALF - 1) @(posedge SYS_CLK);
  endtask
  task automatic send_byte(input logic [7:0] b, input logic quad);
    logic [3:0] r;
    if (quad)
    begin
      tick(b[7:4], 1'b0, r);
      tick(b[3:0], 1'b0, r);
    end
    else
      for (int i = 7; i >= 0; i--)
        tick({3'h0, b[i]}, 1'b0, r);
  endtask
  task automatic open_frame();
    @(posedge SYS_CLK);
    CS_N <= 1'b0;
    repeat (HALF) @(posedge SYS_CLK);
  endtask
  task automatic close_frame();
    @(posedge SYS_CLK);
    SCK <= 1'b0;
    repeat (HALF) @(posedge SYS_CLK);
    CS_N <= 1'b1;
    repeat (2 * HALF) @(posedge SYS_CLK);
  endtask
  // one opcode per frame
  task automatic cmd(input logic [7:0] op, input logic quad);
    open_frame();
    send_byte(op, quad);
    close_frame();
  endtask
endmodule

// ---- flash_mode_switch_and_soft_reset_tb.sv ----
`timescale 1ns/1ns
module flash_mode_switch_and_soft_reset_tb;
  import fms_pkg::*;
  // long enough that a whole command frame falls inside recovery
  localparam int RESET_W = 200;
  logic sys_clk, rst, qe, wel_set, sus_set, sck, cs_n;
  logic quad, write_enable_latch, suspend_status_bit, busy, abort;
  logic [3:0] io_in, io_out, io_oe, hi, lo;
  logic [ADDR_W-1:0] raddr;
  logic [7:0] rdata, params, crm, prm;
  logic [2:0] wbits;
  int mismatches, check_count, aborts, busy_len, seed;
  int wlen, dcnt, start, a;
  // memory stand-in: each byte is a function of its address
  assign rdata = raddr[7:0] ^ 8'hA5;
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    if (abort === 1'b1)
      aborts <= aborts + 1;
    if (busy === 1'b1)
      busy_len <= busy_len + 1;
  end
  fms_core #(.RESET_WAIT(RESET_W)) dut_u (
    .SYS_CLK(sys_clk), .RST(rst), .CE(1'b1), .SCK(sck), .CS_N(cs_n),
    .IO_IN(io_in), .IO_OUT(io_out), .IO_OE(io_oe), .QUAD_ENABLE(qe),
    .WEL_SET(wel_set), .SUS_SET(sus_set), .READ_DATA(rdata),
    .QUAD_MODE(quad), .WRITE_ENABLE_LATCH(write_enable_latch), .SUSPEND_STATUS(suspend_status_bit),
    .BUSY(busy), .ABORT(abort), .READ_ADDR(raddr), .READ_PARAMS(params),
    .CONT_READ_MODE(crm), .WRAP_BITS(wbits));
  fms_host host_u (.SYS_CLK(sys_clk), .SCK(sck), .CS_N(cs_n),
    .IO_IN(io_in), .IO_OUT(io_out), .IO_OE(io_oe));
  task automatic check(input logic [63:0] got, exp, input string m);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error %0t: %s got %0h want %0h", $time, m, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic set_params(input logic [7:0] p);
    host_u.open_frame();
    host_u.send_byte(CMD_SET_PARAMS, 1'b1);
    host_u.send_byte(p, 1'b1);
    host_u.close_frame();
  endtask
  task automatic wait_idle();
    int k;
    for (k = 0; k < 1000 && busy !== 1'b0; k++)
      @(posedge sys_clk);
    if (k == 1000)
    begin
      mismatches++;
      $display("Error %0t: busy stuck", $time);
      print_verdict();
    end
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    seed = 32'h8a8f;
    rst <= 1'b1;
    qe <= 1'b0;
    wel_set <= 1'b0;
    sus_set <= 1'b0;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (5) @(posedge sys_clk);
    check(quad, 0, "spi at start");
    check(params, PARAMS_RESET, "params");
    check({write_enable_latch, suspend_status_bit, wbits, crm}, 0, "volatile");
    wel_set <= 1'b1;
    sus_set <= 1'b1;
    @(posedge sys_clk);
    wel_set <= 1'b0;
    sus_set <= 1'b0;
    host_u.cmd(CMD_ENTER_QUAD, 1'b0);
    check(quad, 0, "enter, qe low");
    qe <= 1'b1;
    host_u.cmd(CMD_ENTER_QUAD, 1'b0);
    check({quad, write_enable_latch, suspend_status_bit, params}, {3'h7, 8'h00}, "enter");
    $display("test mode entry done");
    for (int i = 0; i < 4; i++)
    begin
      wlen = 8 << i;
      dcnt = 8 - 2 * i;
      start = $random(seed) & 32'hFFFFFF;
      prm = 8'((3 - i) << 4 | i);
      set_params(prm);
      check(params, prm, "params");
      host_u.open_frame();
      host_u.send_byte(CMD_WRAP_READ, 1'b1);
      for (int b = 2; b >= 0; b--)
        host_u.send_byte(8'(start >> 8 * b), 1'b1);
      repeat (dcnt) host_u.tick(4'h0, 1'b1, hi);
      for (int k = 0; k < wlen + 3; k++)
      begin
        host_u.tick(4'h0, 1'b1, hi);
        host_u.tick(4'h0, 1'b1, lo);
        a = start & ~(wlen - 1) | (start + k) & (wlen - 1);
        check({hi, lo}, 8'(a) ^ 8'hA5, "wrap byte");
      end
      host_u.close_frame();
    end
    $display("test wrap read done");
    host_u.cmd(CMD_RESET_EN, 1'b1);
    set_params(8'h21);
    host_u.cmd(CMD_RESET, 1'b1);
    check({aborts, quad, params}, {32'd0, 9'h121}, "disarm");
    host_u.cmd(CMD_EXIT_QUAD, 1'b1);
    check({quad, write_enable_latch, suspend_status_bit, params[1:0]}, 5'b01101, "exit");
    $display("test disarm and exit done");
    check(busy, 0, "idle before reset");
    busy_len = 0;
    host_u.cmd(CMD_RESET_EN, 1'b0);
    host_u.cmd(CMD_RESET, 1'b0);
    check({aborts, write_enable_latch, suspend_status_bit, params}, {32'd1, 10'h0}, "spi reset");
    wait_idle();
    check(busy_len, RESET_W, "recovery");
    host_u.cmd(CMD_ENTER_QUAD, 1'b0);
    set_params(8'h33);
    busy_len = 0;
    host_u.cmd(CMD_RESET_EN, 1'b1);
    host_u.cmd(CMD_RESET, 1'b1);
    host_u.cmd(CMD_ENTER_QUAD, 1'b0);
    check({aborts, quad, params}, {32'd2, 9'h0}, "quad reset");
    wait_idle();
    check(busy_len, RESET_W, "recovery");
    $display("test soft reset done");
    print_verdict();
  end
endmodule
